// File: hw/tspg_pkg.sv
// shared constants and types of the trapezoid step profile generator
package tspg_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned TICK_US      = 1000;
    localparam int unsigned TICK_CYCLES  = TICK_US * CLK_MHZ;
    localparam int unsigned RATE_SCALE   = 1000;

    // ==========================================================
    // widths
    localparam int unsigned SPD_W  = 21;
    localparam int unsigned ACC_W  = 13;
    localparam int unsigned LEN_W  = 24;
    localparam int unsigned NCO_W  = 28;
    localparam int unsigned ADDR_W = 8;
    localparam logic [NCO_W-1:0] NCO_MOD = 28'h5f5e100;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_VSTART = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_VPROG  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_ACCEL  = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_DECEL  = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_LENGTH = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_SPEED  = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_STEPS  = 8'h20;

    // ==========================================================
    // field positions
    localparam int unsigned CTRL_GO_BIT    = 0;
    localparam int unsigned CTRL_ABORT_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_DONE_BIT  = 1;
    localparam int unsigned STAT_SHAPE_LSB = 2;
    localparam int unsigned STAT_STATE_LSB = 4;

    // ==========================================================
    // reset values
    localparam logic [SPD_W-1:0] RST_VSTART = 21'h000064;
    localparam logic [SPD_W-1:0] RST_VPROG  = 21'h0007d0;
    localparam logic [ACC_W-1:0] RST_ACCEL  = 13'h0032;
    localparam logic [ACC_W-1:0] RST_DECEL  = 13'h0032;
    localparam logic [LEN_W-1:0] RST_LENGTH = 24'h0003e8;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCEL  = 2'b01,
        ST_CRUISE = 2'b10,
        ST_DECEL  = 2'b11
    } tspg_state_t;

    typedef enum logic [1:0] {
        SH_TRAP     = 2'b00,
        SH_TRI_PEAK = 2'b01,
        SH_TRI_LOW  = 2'b10
    } tspg_shape_t;

endpackage

// File: hw/tspg_rate_if.sv
// rate/step link between profile control and step pulse generator
`timescale 1ns/1ps
`default_nettype none
interface tspg_rate_if;
    logic                     ce;
    logic                     run;
    logic [tspg_pkg::SPD_W-1:0] rate;
    logic                     step;
    modport ctl (output ce, output run, output rate, input step);
    modport gen (input ce, input run, input rate, output step);
endinterface
`default_nettype wire

// File: hw/tspg_step_gen.sv
// phase accumulator turning a step rate in steps/s into step pulses
`timescale 1ns/1ps
`default_nettype none
module tspg_step_gen
    import tspg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    tspg_rate_if.gen rif
);

    // ==========================================================
    // accumulator: one step each time CLK_HZ worth of rate piles up
    logic [NCO_W-1:0] phase_r;
    logic [NCO_W-1:0] phase_nxt;
    logic             step_r;
    wire  [NCO_W-1:0] sum_w  = phase_r + NCO_W'(rif.rate);
    wire              wrap_w = (sum_w >= NCO_MOD);

    // phase is cleared between moves so every move starts alike
    assign phase_nxt = !rif.run ? '0 : (wrap_w ? sum_w - NCO_MOD : sum_w);
    assign rif.step  = step_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= '0;
            step_r  <= 1'b0;
        end else if (rif.ce) begin
            phase_r <= phase_nxt;
            step_r  <= rif.run & wrap_w;
        end
    end

endmodule
`default_nettype wire

// File: hw/tspg_top.sv
// trapezoid step profile generator with apb register access
//
// What this block does
// [R1] ramp rates are steps/s per millisecond, the host divides by 1000.
// [R2] during acceleration the rate rises linearly from start speed.
// [R3] ramp distance is ramp time times the mean of start and top speed.
// [R4] the separate deceleration rate brings speed back to start speed.
// [R5] ramps shorter than the move give a trapezoid with a cruise phase.
// [R6] the cruise covers the move minus both ramps at programmed speed.
// [R7] ramps equal to the move give a triangle with one step at top speed.
// [R8] ramps longer than the move give a triangle below programmed speed.
// [R9] the host should pick start speed near sqrt of accel in steps/s2.
// [R10] rate changes once per millisecond tick and is clamped at limits.
`timescale 1ns/1ps
`default_nettype none
module tspg_top #(
    parameter int unsigned TICK_CYCLES = tspg_pkg::TICK_CYCLES
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         ce,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [tspg_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output var  logic [31:0]                  prdata,
    output var  logic                         pready,
    output var  logic                         pslverr,
    output var  logic                         step_out
);
    import tspg_pkg::*;

    // ==========================================================
    // registers
    logic [SPD_W-1:0] vstart_r, vprog_r;
    logic [ACC_W-1:0] accel_r, decel_r;
    logic [LEN_W-1:0] length_r;
    logic [SPD_W-1:0] vs_r, vtop_r, v_r;
    logic [ACC_W-1:0] a_r, d_r;
    logic [LEN_W-1:0] len_r, steps_r;
    logic             cruise_step_r;
    logic             done_r;
    logic [31:0]      tick_cnt_r;
    tspg_state_t      state_r, state_nxt;
    tspg_shape_t      shape_r;

    tspg_rate_if rif ();

    tspg_step_gen u_gen (
        .pclk    (pclk),
        .presetn (presetn),
        .rif     (rif)
    );

    assign rif.ce   = ce;
    assign rif.run  = (state_r != ST_IDLE);
    assign rif.rate = v_r;

    // ==========================================================
    // apb decode; answer one cycle into the access phase
    wire acc_w   = psel & penable & ~pready;
    wire done_w  = psel & penable & pready;
    wire wr_w    = done_w & pwrite;
    wire hit_w   = (paddr == ADDR_CTRL)   | (paddr == ADDR_VSTART) |
                   (paddr == ADDR_VPROG)  | (paddr == ADDR_ACCEL)  |
                   (paddr == ADDR_DECEL)  | (paddr == ADDR_LENGTH) |
                   (paddr == ADDR_STATUS) | (paddr == ADDR_SPEED)  |
                   (paddr == ADDR_STEPS);
    wire idle_w  = (state_r == ST_IDLE);
    wire go_w    = wr_w & (paddr == ADDR_CTRL) & pwdata[CTRL_GO_BIT] & idle_w;
    wire abort_w = wr_w & (paddr == ADDR_CTRL) & pwdata[CTRL_ABORT_BIT];

    wire [31:0] status_w = {26'h0, state_r, shape_r, done_r, ~idle_w};
    wire [31:0] rd_w =
        (paddr == ADDR_VSTART) ? 32'(vstart_r) :
        (paddr == ADDR_VPROG)  ? 32'(vprog_r)  :
        (paddr == ADDR_ACCEL)  ? 32'(accel_r)  :
        (paddr == ADDR_DECEL)  ? 32'(decel_r)  :
        (paddr == ADDR_LENGTH) ? 32'(length_r) :
        (paddr == ADDR_STATUS) ? status_w      :
        (paddr == ADDR_SPEED)  ? 32'(v_r)      :
        (paddr == ADDR_STEPS)  ? 32'(steps_r)  : 32'h0;

    // ==========================================================
    // profile shape from the programmed values at go time
    // (vp^2 - vs^2)(a + d) against 2*1000*a*d*length, no divider needed
    wire [SPD_W-1:0] top_w  = (vprog_r > vstart_r) ? vprog_r : vstart_r;
    wire [63:0] dv2_w  = 64'(top_w) * 64'(top_w) - 64'(vstart_r) * 64'(vstart_r);
    wire [63:0] ramp_w = dv2_w * (64'(accel_r) + 64'(decel_r));
    // [R3] ramp distance compare
    wire [63:0] move_w = 64'(length_r) * 64'(accel_r) * 64'(decel_r)
                         * 64'(2 * RATE_SCALE);
    // [R5] trapezoid when ramps are short
    // [R7] exact fit gives triangle reaching top speed
    // [R8] longer ramps give a low triangle
    wire tspg_shape_t shape_w = (ramp_w < move_w)  ? SH_TRAP     :
                                (ramp_w == move_w) ? SH_TRI_PEAK : SH_TRI_LOW;

    // ==========================================================
    // running decisions on the latched move
    // [R1] per-ms rate times 1000 gives steps/s2
    wire [LEN_W-1:0] rem_w  = len_r - steps_r;
    wire [63:0] need_w = 64'(v_r) * 64'(v_r) - 64'(vs_r) * 64'(vs_r);
    wire [63:0] have_w = 64'(rem_w) * 64'(d_r) * 64'(2 * RATE_SCALE);
    wire        brake_w = (have_w <= need_w);
    wire        tick_w  = (tick_cnt_r == 32'(TICK_CYCLES - 1));
    wire        last_w  = rif.step & (steps_r + 24'h000001 == len_r);

    wire [SPD_W:0] up_w   = {1'b0, v_r} + (SPD_W+1)'(a_r);
    wire           top_hit_w = (up_w >= {1'b0, vtop_r});
    wire [SPD_W:0] floor_w = {1'b0, vs_r} + (SPD_W+1)'(d_r);
    // [R10] clamp at commanded and starting speed
    wire [SPD_W-1:0] v_up_w = top_hit_w ? vtop_r : up_w[SPD_W-1:0];
    wire [SPD_W-1:0] v_dn_w = ({1'b0, v_r} > floor_w) ?
                              (v_r - SPD_W'(d_r)) : vs_r;

    // ==========================================================
    // motion sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go_w && length_r != '0) begin
                    state_nxt = ST_ACCEL;
                end
            end
            ST_ACCEL: begin
                // [R8] brake before top speed
                if (brake_w) begin
                    state_nxt = ST_DECEL;
                end else if (tick_w && top_hit_w) begin
                    state_nxt = ST_CRUISE;
                end
            end
            ST_CRUISE: begin
                // [R6] cruise until the remainder equals decel distance
                // [R7] at least one step at top speed first
                if (brake_w && cruise_step_r) begin
                    state_nxt = ST_DECEL;
                end
            end
            ST_DECEL: begin
                state_nxt = ST_DECEL;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (state_r != ST_IDLE && (last_w || abort_w)) begin
            state_nxt = ST_IDLE;
        end
    end

    // ==========================================================
    // software registers and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vstart_r <= RST_VSTART;
            vprog_r  <= RST_VPROG;
            accel_r  <= RST_ACCEL;
            decel_r  <= RST_DECEL;
            length_r <= RST_LENGTH;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0;
        end else if (ce) begin
            pready  <= acc_w;
            pslverr <= acc_w & ~hit_w;
            prdata  <= acc_w ? rd_w : 32'h0;
            if (wr_w && paddr == ADDR_VSTART) vstart_r <= pwdata[SPD_W-1:0];
            if (wr_w && paddr == ADDR_VPROG)  vprog_r  <= pwdata[SPD_W-1:0];
            if (wr_w && paddr == ADDR_ACCEL)  accel_r  <= pwdata[ACC_W-1:0];
            if (wr_w && paddr == ADDR_DECEL)  decel_r  <= pwdata[ACC_W-1:0];
            if (wr_w && paddr == ADDR_LENGTH) length_r <= pwdata[LEN_W-1:0];
        end
    end

    // ==========================================================
    // move state; parameters are latched so bus writes cannot bend a move
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r       <= ST_IDLE;
            shape_r       <= SH_TRAP;
            vs_r          <= '0;
            vtop_r        <= '0;
            v_r           <= '0;
            a_r           <= '0;
            d_r           <= '0;
            len_r         <= '0;
            steps_r       <= '0;
            cruise_step_r <= 1'b0;
            done_r        <= 1'b0;
            tick_cnt_r    <= 32'h0;
            step_out      <= 1'b0;
        end else if (ce) begin
            state_r    <= state_nxt;
            step_out   <= rif.step & ~idle_w;
            tick_cnt_r <= (tick_w || idle_w) ? 32'h0 : tick_cnt_r + 32'h1;
            if (go_w) begin
                shape_r       <= shape_w;
                vs_r          <= vstart_r;
                vtop_r        <= top_w;
                v_r           <= vstart_r;
                a_r           <= accel_r;
                d_r           <= decel_r;
                len_r         <= length_r;
                steps_r       <= '0;
                cruise_step_r <= 1'b0;
                // a zero-length move completes at once
                done_r        <= (length_r == '0);
            end else begin
                if (rif.step && !idle_w) steps_r <= steps_r + 24'h000001;
                if (rif.step && state_r == ST_CRUISE) cruise_step_r <= 1'b1;
                // done is only cleared by go, which idle guards, so no race
                if (last_w) done_r <= 1'b1;
                if (tick_w) begin
                    // [R2] linear rise each tick
                    // [R10] one update per ms tick
                    if (state_r == ST_ACCEL && !brake_w) v_r <= v_up_w;
                    // [R4] fall by the deceleration rate
                    if (state_r == ST_DECEL) v_r <= v_dn_w;
                end
                if (state_nxt == ST_IDLE) v_r <= '0;
            end
        end
    end

endmodule
`default_nettype wire

// File: bench/tspg_host.sv
// apb host model writing move parameters into the generator
`timescale 1ns/1ps
`default_nettype none
module tspg_host (
    input  wire logic                        pclk,
    input  wire logic [31:0]                 prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr,
    output var  logic                        psel,
    output var  logic                        penable,
    output var  logic                        pwrite,
    output var  logic [tspg_pkg::ADDR_W-1:0] paddr,
    output var  logic [31:0]                 pwdata
);
    import tspg_pkg::*;
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    end
    // ==========================================================
    // one apb transfer, request held until pready is sampled
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // ==========================================================
    // rates given in steps/s2, scaled to steps/s per ms
    task automatic load(input int vs, vp, acc, dec, len);
        logic [31:0] q;
        logic        e;
        xfer(1, ADDR_VSTART, vs, q, e);
        xfer(1, ADDR_VPROG, vp, q, e);
        xfer(1, ADDR_ACCEL, acc / RATE_SCALE, q, e);
        xfer(1, ADDR_DECEL, dec / RATE_SCALE, q, e);
        xfer(1, ADDR_LENGTH, len, q, e);
    endtask
endmodule
`default_nettype wire

// File: bench/tspg_top_sva.sv
// port assertions for the step profile generator
`timescale 1ns/1ps
`default_nettype none
module tspg_chk #(
    parameter int unsigned TICK_CYCLES = 50
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        step_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // bus answer
    a_rdy_timing: assert property (psel && penable && !pready && ce
        |=> pready || !ce) else $error("pready late");
    a_rdy_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_rdy_in_acc: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_with_rdy: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_rdata_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_err_unmap: assert property (pready && paddr > 8'h20
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_err_mapped: assert property (pready && paddr <= 8'h20
        && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped refused");
    // ==========================================================
    // steps: rate clamped below 2.1e6/s keeps pulses far apart
    a_step_pulse: assert property (step_out |=> !step_out [*8])
        else $error("step pulses too close");
    // enable low must not let a step through
    a_freeze_step: assert property (!ce && !step_out |=> !step_out)
        else $error("step while frozen");
    cover property (!ce);
    cover property (pready && pslverr);
    cover property (pready && pwrite);
    cover property (step_out);
endmodule
bind tspg_top tspg_chk #(.TICK_CYCLES(TICK_CYCLES)) tspg_chk_inst (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .step_out);
`default_nettype wire

// File: bench/test_tspg_top.sv
// self-checking bench for the step profile generator
`timescale 1ns/1ps
`default_nettype none
module test_tspg_top;
    import tspg_pkg::*;
    typedef struct {int vs; int vp; int acc; int dec; int len;
                    tspg_shape_t sh;} tspg_row_t;
    logic              pclk = 0, presetn = 0, ce = 1;
    logic              psel, penable, pwrite, pready, pslverr, step_out;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, q;
    logic              e;
    int                error_cnt = 0, checked = 0, step_cnt = 0, cyc = 0;
    int                n;
    // ramps of 60 steps each at 6667 steps/s per ms, last row's decel 120 steps at 3334
    tspg_row_t rows [4] = '{
        '{2000000, 2000200, 6667000, 6667000, 300, SH_TRAP},
        '{2000000, 2000200, 6667000, 6667000, 120, SH_TRI_PEAK},
        '{2000000, 2000200, 6667000, 6667000, 60, SH_TRI_LOW},
        '{2000000, 2000200, 6667000, 3334000, 300, SH_TRAP}};
    logic [7:0]  raddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] rval [7] = '{0, 100, 2000, 50, 50, 1000, 0};
    tspg_top #(.TICK_CYCLES(50)) tspg_top_inst (.pclk, .presetn, .ce,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .step_out);
    tspg_host tspg_host_inst (.pclk, .prdata, .pready, .pslverr, .psel,
        .penable, .pwrite, .paddr, .pwdata);
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (step_out === 1'b1) step_cnt <= step_cnt + 1;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tspg_host_inst.xfer(1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        tspg_host_inst.xfer(0, a, 0, q, e);
    endtask
    task automatic wait_steps(input int k);
        for (int i = 0; i < 5000 && step_cnt < k; i++) @(posedge pclk);
    endtask
    // polls status until the move leaves busy; cruise speed checked once
    task automatic wait_idle(input int vp);
        logic [31:0] spd;
        bit          seen;
        seen = 0;
        for (int i = 0; i < 5000; i++) begin
            rd(ADDR_STATUS);
            if (q[STAT_BUSY_BIT] === 1'b0) break;
            if (q[5:4] === ST_CRUISE && !seen) begin
                rd(ADDR_SPEED);
                spd = q;
                // speed is only trusted if cruise held on both sides of it
                rd(ADDR_STATUS);
                if (q[5:4] === ST_CRUISE) begin
                    chk(spd, vp);
                    seen = 1;
                end
            end
        end
        rd(ADDR_STATUS);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 7; i++) begin
            rd(raddr[i]);
            chk(q, rval[i]);
        end
        foreach (rows[i]) begin
            tspg_host_inst.load(rows[i].vs, rows[i].vp, rows[i].acc,
                                rows[i].dec, rows[i].len);
            step_cnt = 0;
            wr(ADDR_CTRL, 1);
            wait_idle(rows[i].vp);
            // shape from summed ramp distances, whole move covered
            chk(q, {26'h0, ST_IDLE, rows[i].sh, 2'b10});
            rd(ADDR_STEPS);
            chk(q, rows[i].len);
            chk(step_cnt, rows[i].len);
        end
        // unmapped place is refused
        rd(8'h24);
        chk(q, 32'h0);
        chk(e, 1'b1);
        wr(8'h24, 32'h5);
        chk(e, 1'b1);
        // zero length finishes with no steps; start speed near sqrt(accel)
        tspg_host_inst.load(141, 2000, 20000, 25000, 0);
        rd(ADDR_DECEL);
        chk(q, 32'd25);
        step_cnt = 0;
        wr(ADDR_CTRL, 1);
        wait_idle(0);
        chk({q[1:0], 30'h0}, {2'b10, 30'h0});
        chk(step_cnt, 0);
        // go while busy is ignored; enable low freezes the move
        tspg_host_inst.load(rows[0].vs, rows[0].vp, rows[0].acc,
                            rows[0].dec, 120);
        step_cnt = 0;
        wr(ADDR_CTRL, 1);
        wait_steps(5);
        ce <= 1'b0;
        n = step_cnt;
        repeat (200) @(posedge pclk);
        chk(step_cnt, n);
        ce <= 1'b1;
        wr(ADDR_LENGTH, 5);
        wr(ADDR_CTRL, 1);
        wait_idle(rows[0].vp);
        rd(ADDR_STEPS);
        chk(q, 120);
        chk(step_cnt, 120);
        // abort stops at once without done
        wr(ADDR_LENGTH, 300);
        step_cnt = 0;
        wr(ADDR_CTRL, 1);
        wait_steps(5);
        wr(ADDR_CTRL, 2);
        rd(ADDR_STATUS);
        chk(q[1:0], 2'b00);
        n = step_cnt;
        repeat (300) @(posedge pclk);
        chk(step_cnt, n);
        // reset in mid-move goes back to idle and reset values
        wr(ADDR_CTRL, 1);
        wait_steps(n + 5);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        n = step_cnt;
        rd(ADDR_STATUS);
        chk(q, 32'h0);
        rd(ADDR_LENGTH);
        chk(q, 32'(RST_LENGTH));
        repeat (300) @(posedge pclk);
        chk(step_cnt, n);
        print_verdict();
    end
endmodule
`default_nettype wire
